// File: sim/fbw_comm_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fbw_comm_cfg_chk #(
   parameter TENTH_CYCLES = 10
) (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_telegram_valid,
   input wire logic [5:0]  i_telegram_addr,
   input wire logic        s_axi_bvalid,
   input wire logic [5:0]  o_station_address_setting,
   input wire logic [2:0]  o_bit_rate_setting,
   input wire logic [15:0] o_bit_period_cycles,
   input wire logic        o_comm_loss,
   input wire logic        o_trip,
   input wire logic        o_coast_stop,
   input wire logic        o_ramp_stop,
   input wire logic        o_preset4_run
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic        kick_r;
   logic [15:0] exp_per;
   always_comb begin
      case (o_bit_rate_setting)
         3'h0: exp_per = 16'h65b9;
         3'h1: exp_per = 16'h32dc;
         3'h2: exp_per = 16'h196e;
         3'h3: exp_per = 16'h10f4;
         3'h4: exp_per = 16'h0cb7;
         default: exp_per = 16'h087a;
      endcase
   end
   // The action outputs are registered in the same flop stage as the loss flag.
   always_ff @(posedge i_clock) begin
      if (i_rst) kick_r <= 1'b0;
      else kick_r <= i_telegram_valid &&
                     (i_telegram_addr == o_station_address_setting);
   end
   a_coast_needs_loss: assert property (
      o_coast_stop |-> o_comm_loss || $past(o_comm_loss))
      else $error("coast stop without link loss");
   a_ramp_needs_loss: assert property (
      o_ramp_stop |-> (o_comm_loss || $past(o_comm_loss)) && !o_coast_stop)
      else $error("ramp stop without link loss");
   a_preset_needs_loss: assert property (
      o_preset4_run |-> (o_comm_loss || $past(o_comm_loss)) &&
                        !o_ramp_stop && !o_coast_stop)
      else $error("preset run without link loss");
   a_trip_stays_set: assert property (
      $fell(o_trip) |-> $rose(s_axi_bvalid))
      else $error("trip dropped without a status write");
   a_kick_clears_loss: assert property (
      i_telegram_valid && o_comm_loss &&
      i_telegram_addr == o_station_address_setting |-> ##2 !o_comm_loss)
      else $error("addressed telegram left loss set");
   a_loss_after_silence: assert property (
      $rose(o_comm_loss) |-> !$past(kick_r))
      else $error("loss raised right after a telegram");
   a_rate_in_range: assert property (
      o_bit_rate_setting <= 3'h5)
      else $error("bit rate code out of range");
   a_bit_period_match: assert property (
      o_bit_period_cycles == $past(exp_per))
      else $error("bit period does not match rate");
endmodule // fbw_comm_cfg_chk
`default_nettype wire

// File: sim/fbw_link_master.sv
`timescale 1ns/1ps
`default_nettype none
module fbw_link_master (
   input  wire logic       i_clock,
   output logic            o_valid,
   output logic [5:0]      o_addr
);
   initial begin
      o_valid = 1'b0;
      o_addr  = 6'h00;
   end
   // A decoded telegram shows as one pulse; no character timing is kept.
   // The master is assumed to use the rate and framing the device holds.
   task send(input logic [5:0] a);
      @(posedge i_clock);
      o_valid <= 1'b1;
      o_addr  <= a;
      @(posedge i_clock);
      o_valid <= 1'b0;
      o_addr  <= ~a;
   endtask
endmodule // fbw_link_master
`default_nettype wire

// File: sim/test_fbw_comm_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module test_fbw_comm_cfg;
   localparam TC = 10;
   localparam int BPS [6] = '{9600, 19200, 38400, 57600, 76800, 115200};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [5:0]  awa = 6'h00, ara = 6'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic        ms = 1'b0;
   logic [1:0]  dig = 2'h2;
   logic [15:0] q0 = 16'h1234, pw = 16'h0190;
   logic [79:0] sp = 80'h7777_0000_0000_0000_3333;
   wire         awr, wr_r, bv, arr, rv, tv, ramp, loss, trip, cst, rmp, pre;
   wire  [1:0]  br, rr, frm;
   wire  [31:0] rd;
   wire  [5:0]  ta, sta;
   wire  [2:0]  rate;
   wire  [15:0] bper, w4;
   int          errors = 0, n_tests = 0, cyc = 0;
   logic [31:0] d;
   logic [1:0]  r;
   always #2 clk = ~clk;
   fbw_link_master lm (.i_clock(clk), .o_valid(tv), .o_addr(ta));
   fbw_comm_cfg #(.TENTH_CYCLES(TC)) dut (
      .i_clock(clk), .i_rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .i_telegram_valid(tv), .i_telegram_addr(ta), .i_motor_stopped(ms),
      .i_qty0_word(q0), .i_power_word(pw), .i_dig_in(dig),
      .i_spare_words(sp), .o_station_address_setting(sta),
      .o_bit_rate_setting(rate), .o_bit_period_cycles(bper),
      .o_char_framing_setting(frm), .o_ramp_source_select(ramp),
      .o_fourth_process_word(w4), .o_comm_loss(loss), .o_trip(trip),
      .o_coast_stop(cst), .o_ramp_stop(rmp), .o_preset4_run(pre));
   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [15:0] per(input int k);
      return 16'(250000000 / BPS[k]);
   endfunction
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task conclude;
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] e);
      @(posedge clk);
      awa <= a;
      awv <= 1'b1;
      wd  <= v;
      wv  <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
      chk("bresp", br, e);
   endtask
   task rdt(input logic [5:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d = rd;
      r = rr;
      rry <= 1'b0;
   endtask
   task rchk(input logic [5:0] a, input logic [31:0] e);
      rdt(a);
      chk("rdata", d, e);
      chk("rresp", r, 2'h0);
   endtask
   task settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_defaults;
      logic [31:0] ex [9];
      ex = '{6'h00, 3'h5, 2'h0, 6'h0a, 2'h0, 1'h0, 3'h1, 2'h0, 16'h0000};
      ex[8] = per(5);
      for (int i = 0; i < 9; i++)
         rchk(6'(i * 4), ex[i]);
      wr(6'h0c, 32'h0000_0000, 2'h0);
      wr(6'h0c, 32'h0000_0033, 2'h0);
      rchk(6'h0c, 32'h0000_0000);
   endtask
   task t_settings;
      for (int k = 0; k < 6; k++) begin
         wr(6'h04, k, 2'h0);
         settle(2);
         chk("rate", rate, k);
         chk("period", bper, per(k));
      end
      wr(6'h04, 32'h0000_0006, 2'h0);
      wr(6'h20, 32'h0000_0000, 2'h2);
      settle(1);
      chk("rate", rate, 3'h5);
      rchk(6'h20, per(5));
      for (int f = 0; f < 4; f++) begin
         wr(6'h08, f, 2'h0);
         settle(1);
         chk("framing", frm, f);
      end
      wr(6'h00, 32'h0000_003f, 2'h0);
      settle(1);
      chk("station", sta, 6'h3f);
      wr(6'h00, 32'h0000_0005, 2'h0);
      wr(6'h14, 32'h0000_0001, 2'h0);
      settle(1);
      chk("ramp source", ramp, 1'h1);
      rdt(6'h28);
      chk("rresp", r, 2'h2);
      wr(6'h2c, 32'h0000_0000, 2'h2);
   endtask
   task t_word4;
      logic [15:0] ex;
      int          sel [5];
      sel = '{0, 1, 2, 3, 7};
      foreach (sel[i]) begin
         ex = sel[i] == 0 ? q0 : sel[i] == 1 ? pw :
              sel[i] == 2 ? {14'h0000, dig} : sp[(sel[i] - 3) * 16 +: 16];
         wr(6'h18, sel[i], 2'h0);
         settle(4);
         chk("word4", w4, ex);
      end
   endtask
   task t_watchdog;
      for (int a = 0; a < 4; a++) begin
         wr(6'h10, a, 2'h0);
         wr(6'h0c, 32'h0000_0001, 2'h0);
         lm.send(6'h05);
         settle(8);
         chk("loss", loss, 1'h0);
         lm.send(6'h06);
         settle(8);
         chk("loss", loss, 1'h1);
         chk("coast", cst, a == 0);
         chk("ramp stop", rmp, a == 1 || a == 2);
         chk("preset", pre, a == 3);
         chk("trip", trip, a == 0);
         @(posedge clk);
         ms <= (a == 1);
         settle(3);
         chk("trip", trip, a < 2);
         lm.send(6'h05);
         wr(6'h0c, 32'h0000_0000, 2'h0);
         ms <= 1'b0;
         settle(1);
         chk("loss", loss, 1'h0);
         wr(6'h1c, 32'h0000_0002, 2'h0);
         settle(1);
         chk("trip", trip, 1'h0);
      end
      settle(100);
      chk("loss", loss, 1'h0);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         conclude;
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_settings;
      t_word4;
      t_watchdog;
      conclude;
   end
endmodule // test_fbw_comm_cfg
bind fbw_comm_cfg fbw_comm_cfg_chk #(.TENTH_CYCLES(TENTH_CYCLES)) u_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_telegram_valid(i_telegram_valid),
   .i_telegram_addr(i_telegram_addr), .s_axi_bvalid(s_axi_bvalid),
   .o_station_address_setting(o_station_address_setting),
   .o_bit_rate_setting(o_bit_rate_setting),
   .o_bit_period_cycles(o_bit_period_cycles), .o_comm_loss(o_comm_loss),
   .o_trip(o_trip), .o_coast_stop(o_coast_stop),
   .o_ramp_stop(o_ramp_stop), .o_preset4_run(o_preset4_run));
`default_nettype wire

// File: verilog/fbw_comm_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "fbw_defs.vh"

// Notes on behaviour
// - Station address 0 to 63, node/MAC id.
// - Six bit rates, default 115.2 kbps.
// - Four framings, default no parity one stop.
// - Loss declared after 0.1-5.0 s silence; 0.0 disables.
// - Loss action 0..3, default trip and coast.
// - Ramp source internal (0) or fieldbus (1).
// - Fourth word selector 0..7, default 1.
// - Selector 1 gives power, two decimals.
// - Selector 2 gives digital inputs bitfield.
// - Selector 0 gives listed quantity, one decimal.
module fbw_comm_cfg #(
   parameter TENTH_CYCLES = `FBW_TENTH_CYCLES
) (
   input  wire        i_clock,
   input  wire        i_rst,
   // AXI4-Lite slave
   input  wire [5:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [5:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Protocol side
   input  wire        i_telegram_valid,
   input  wire [5:0]  i_telegram_addr,
   input  wire        i_motor_stopped,
   input  wire [15:0] i_qty0_word,
   input  wire [15:0] i_power_word,
   input  wire [1:0]  i_dig_in,
   input  wire [79:0] i_spare_words,
   // Settings and actions
   output reg  [5:0]  o_station_address_setting,
   output reg  [2:0]  o_bit_rate_setting,
   output reg  [15:0] o_bit_period_cycles,
   output reg  [1:0]  o_char_framing_setting,
   output reg         o_ramp_source_select,
   output reg  [15:0] o_fourth_process_word,
   output reg         o_comm_loss,
   output reg         o_trip,
   output reg         o_coast_stop,
   output reg         o_ramp_stop,
   output reg         o_preset4_run
);

   // -------------------------------------------------------------------
   // Settings
   // -------------------------------------------------------------------
   reg [5:0] loss_period_r;
   reg [1:0] loss_action_r;
   reg [2:0] word4_sel_r;
   reg [1:0] act_r;
   reg [1:0] din_meta_r;
   reg [1:0] din_r;
   reg       expired_d_r;

   // -------------------------------------------------------------------
   // Bus slave state
   // -------------------------------------------------------------------
   reg [5:0]  awaddr_r;
   reg [31:0] wdata_r;
   reg        wstrb0_r;
   reg        aw_full_r;
   reg        w_full_r;
   reg        aw_full_nxt;
   reg        w_full_nxt;
   reg        bvalid_nxt;
   reg        rvalid_nxt;
   reg [31:0] rd_mux;
   reg        rd_hit;
   reg        wr_hit;

   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire ar_take  = s_axi_arvalid & s_axi_arready;
   wire do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
   wire wr_ok    = do_write & wstrb0_r;

   wire expired;
   wire kick = i_telegram_valid &&
               (i_telegram_addr == o_station_address_setting);
   wire loss_event = expired & ~expired_d_r;

   fbw_loss_timer #(
      .TENTH_CYCLES (TENTH_CYCLES)
   ) u_timer (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_period  (loss_period_r),
      .i_kick    (kick),
      .o_expired (expired)
   );

   always @* begin
      aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
      w_full_nxt  = (w_full_r | w_take) & ~do_write;
      bvalid_nxt  = do_write | (s_axi_bvalid & ~s_axi_bready);
      rvalid_nxt  = ar_take | (s_axi_rvalid & ~s_axi_rready);
   end

   always @* begin
      wr_hit = 1'b1;
      case (awaddr_r)
         `FBW_OFS_STATION, `FBW_OFS_BITRATE, `FBW_OFS_FRAMING,
         `FBW_OFS_LOSSPER, `FBW_OFS_LOSSACT, `FBW_OFS_RAMPSRC,
         `FBW_OFS_WORD4SEL, `FBW_OFS_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always @* begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[5:2], 2'b00})
         `FBW_OFS_STATION:  rd_mux[5:0]  = o_station_address_setting;
         `FBW_OFS_BITRATE:  rd_mux[2:0]  = o_bit_rate_setting;
         `FBW_OFS_FRAMING:  rd_mux[1:0]  = o_char_framing_setting;
         `FBW_OFS_LOSSPER:  rd_mux[5:0]  = loss_period_r;
         `FBW_OFS_LOSSACT:  rd_mux[1:0]  = loss_action_r;
         `FBW_OFS_RAMPSRC:  rd_mux[0]    = o_ramp_source_select;
         `FBW_OFS_WORD4SEL: rd_mux[2:0]  = word4_sel_r;
         `FBW_OFS_STATUS: begin
            rd_mux[`FBW_ST_LOSS] = o_comm_loss;
            rd_mux[`FBW_ST_TRIP] = o_trip;
         end
         `FBW_OFS_BITCYC:   rd_mux[15:0] = o_bit_period_cycles;
         `FBW_OFS_WORD4:    rd_mux[15:0] = o_fourth_process_word;
         default:           rd_hit       = 1'b0;
      endcase
   end

   // -------------------------------------------------------------------
   // Bus handshakes
   // -------------------------------------------------------------------
   // Readies are registered, so the read address channel stalls one cycle and the write address and data channels two cycles after a
   // transfer; this keeps every output on a flop at the cost of rate.
   always @(posedge i_clock) begin
      if (i_rst) begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         awaddr_r      <= 6'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb0_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FBW_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `FBW_RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         aw_full_r     <= aw_full_nxt;
         w_full_r      <= w_full_nxt;
         if (aw_take)
            awaddr_r <= {s_axi_awaddr[5:2], 2'b00};
         if (w_take) begin
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end
         s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
         s_axi_wready  <= ~w_full_nxt & ~bvalid_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         if (do_write)
            s_axi_bresp <= wr_hit ? `FBW_RESP_OKAY : `FBW_RESP_SLVERR;
         s_axi_arready <= ~rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (ar_take) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `FBW_RESP_OKAY : `FBW_RESP_SLVERR;
         end
      end
   end

   // -------------------------------------------------------------------
   // Setting registers
   // -------------------------------------------------------------------
   // Out-of-range values are dropped so a setting never leaves its range.
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_station_address_setting <= `FBW_STATION_RST;
         o_bit_rate_setting        <= `FBW_BITRATE_RST;
         o_char_framing_setting    <= `FBW_FRAMING_RST;
         loss_period_r             <= `FBW_LOSSPER_RST;
         loss_action_r             <= `FBW_LOSSACT_RST;
         o_ramp_source_select      <= `FBW_RAMPSRC_RST;
         word4_sel_r               <= `FBW_WORD4SEL_RST;
      end else if (wr_ok) begin
         case (awaddr_r)
            `FBW_OFS_STATION:
               o_station_address_setting <= wdata_r[5:0];
            `FBW_OFS_BITRATE:
               if (wdata_r[2:0] <= `FBW_BITRATE_MAX)
                  o_bit_rate_setting <= wdata_r[2:0];
            `FBW_OFS_FRAMING:
               o_char_framing_setting <= wdata_r[1:0];
            `FBW_OFS_LOSSPER:
               if (wdata_r[5:0] <= `FBW_LOSSPER_MAX)
                  loss_period_r <= wdata_r[5:0];
            `FBW_OFS_LOSSACT:
               loss_action_r <= wdata_r[1:0];
            `FBW_OFS_RAMPSRC:
               o_ramp_source_select <= wdata_r[0];
            `FBW_OFS_WORD4SEL:
               word4_sel_r <= wdata_r[2:0];
            default: ;
         endcase
      end
   end

   // Bit period in clock cycles for the character engine.
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_bit_period_cycles <= `FBW_PER_115K2;
      end else begin
         case (o_bit_rate_setting)
            `FBW_BR_9K6:  o_bit_period_cycles <= `FBW_PER_9K6;
            `FBW_BR_19K2: o_bit_period_cycles <= `FBW_PER_19K2;
            `FBW_BR_38K4: o_bit_period_cycles <= `FBW_PER_38K4;
            `FBW_BR_57K6: o_bit_period_cycles <= `FBW_PER_57K6;
            `FBW_BR_76K8: o_bit_period_cycles <= `FBW_PER_76K8;
            default:      o_bit_period_cycles <= `FBW_PER_115K2;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Loss supervision and actions
   // -------------------------------------------------------------------
   // The action is frozen at the moment of loss so a later change of
   // setting cannot turn a running stop into something else.
   always @(posedge i_clock) begin
      if (i_rst) begin
         expired_d_r   <= 1'b0;
         act_r         <= `FBW_ACT_TRIP_COAST;
         o_comm_loss   <= 1'b0;
         o_trip        <= 1'b0;
         o_coast_stop  <= 1'b0;
         o_ramp_stop   <= 1'b0;
         o_preset4_run <= 1'b0;
      end else begin
         expired_d_r <= expired;
         o_comm_loss <= expired;
         if (loss_event)
            act_r <= loss_action_r;
         o_coast_stop  <= expired &
                          (loss_event ? loss_action_r : act_r) ==
                          `FBW_ACT_TRIP_COAST;
         o_ramp_stop   <= expired &
                          ((loss_event ? loss_action_r : act_r) ==
                           `FBW_ACT_RAMP_TRIP |
                           (loss_event ? loss_action_r : act_r) ==
                           `FBW_ACT_RAMP_ONLY);
         o_preset4_run <= expired &
                          (loss_event ? loss_action_r : act_r) ==
                          `FBW_ACT_PRESET4;
         // A new trip beats a software clear in the same cycle.
         if (loss_event && loss_action_r == `FBW_ACT_TRIP_COAST)
            o_trip <= 1'b1;
         else if (expired && !loss_event &&
                  act_r == `FBW_ACT_RAMP_TRIP && i_motor_stopped)
            o_trip <= 1'b1;
         else if (wr_ok && awaddr_r == `FBW_OFS_STATUS &&
                  wdata_r[`FBW_ST_TRIP])
            o_trip <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Fourth process word
   // -------------------------------------------------------------------
   always @(posedge i_clock) begin
      if (i_rst) begin
         din_meta_r            <= 2'h0;
         din_r                 <= 2'h0;
         o_fourth_process_word <= 16'h0000;
      end else begin
         din_meta_r <= i_dig_in;
         din_r      <= din_meta_r;
         case (word4_sel_r)
            `FBW_W4_QTY0:
               o_fourth_process_word <= i_qty0_word;
            `FBW_W4_POWER:
               o_fourth_process_word <= i_power_word;
            `FBW_W4_DIGIN:
               o_fourth_process_word <= {14'h0000, din_r};
            default:
               o_fourth_process_word <=
                  i_spare_words[(word4_sel_r - 3'h3) * 16 +: 16];
         endcase
      end
   end

endmodule // fbw_comm_cfg
`default_nettype wire

// File: verilog/fbw_defs.vh
`ifndef FBW_DEFS_VH
`define FBW_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FBW_OFS_STATION   6'h00
`define FBW_OFS_BITRATE   6'h04
`define FBW_OFS_FRAMING   6'h08
`define FBW_OFS_LOSSPER   6'h0c
`define FBW_OFS_LOSSACT   6'h10
`define FBW_OFS_RAMPSRC   6'h14
`define FBW_OFS_WORD4SEL  6'h18
`define FBW_OFS_STATUS    6'h1c
`define FBW_OFS_BITCYC    6'h20
`define FBW_OFS_WORD4     6'h24

// ----------------------------------------------------------------------
// Field limits and reset values
// ----------------------------------------------------------------------
`define FBW_STATION_RST   6'h00
`define FBW_BITRATE_MAX   3'h5
`define FBW_BITRATE_RST   3'h5
`define FBW_FRAMING_RST   2'h0
`define FBW_LOSSPER_MAX   6'h32
`define FBW_LOSSPER_RST   6'h0a
`define FBW_LOSSACT_RST   2'h0
`define FBW_RAMPSRC_RST   1'h0
`define FBW_WORD4SEL_RST  3'h1

// Bit rate codes.
`define FBW_BR_9K6        3'h0
`define FBW_BR_19K2       3'h1
`define FBW_BR_38K4       3'h2
`define FBW_BR_57K6       3'h3
`define FBW_BR_76K8       3'h4
`define FBW_BR_115K2      3'h5

// Loss action codes.
`define FBW_ACT_TRIP_COAST 2'h0
`define FBW_ACT_RAMP_TRIP  2'h1
`define FBW_ACT_RAMP_ONLY  2'h2
`define FBW_ACT_PRESET4    2'h3

// Fourth word selector codes.
`define FBW_W4_QTY0       3'h0
`define FBW_W4_POWER      3'h1
`define FBW_W4_DIGIN      3'h2

// Status bits.
`define FBW_ST_LOSS       0
`define FBW_ST_TRIP       1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FBW_CLK_HZ        250000000
`define FBW_LOSS_UNIT_MS  100
`define FBW_TENTH_CYCLES  (`FBW_CLK_HZ / 1000 * `FBW_LOSS_UNIT_MS)
// Bit periods in clock cycles at the clock above, rounded down.
`define FBW_PER_9K6       16'h65b9
`define FBW_PER_19K2      16'h32dc
`define FBW_PER_38K4      16'h196e
`define FBW_PER_57K6      16'h10f4
`define FBW_PER_76K8      16'h0cb7
`define FBW_PER_115K2     16'h087a

`define FBW_RESP_OKAY     2'h0
`define FBW_RESP_SLVERR   2'h2

`endif

// File: verilog/fbw_loss_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "fbw_defs.vh"

module fbw_loss_timer #(
   parameter TENTH_CYCLES = `FBW_TENTH_CYCLES,
   parameter PRE_W        = 25
) (
   input  wire       i_clock,
   input  wire       i_rst,
   input  wire [5:0] i_period,
   input  wire       i_kick,
   output reg        o_expired
);

   reg [PRE_W-1:0] pre_r;
   reg [5:0]       tenth_r;
   wire            tick = (pre_r == TENTH_CYCLES - 1);

   // A telegram in the same cycle as expiry wins: the link is alive.
   always @(posedge i_clock) begin
      if (i_rst) begin
         pre_r     <= {PRE_W{1'b0}};
         tenth_r   <= 6'h00;
         o_expired <= 1'b0;
      end else if (i_kick) begin
         pre_r     <= {PRE_W{1'b0}};
         tenth_r   <= 6'h00;
         o_expired <= 1'b0;
      end else if (i_period == 6'h00) begin
         pre_r     <= {PRE_W{1'b0}};
         tenth_r   <= 6'h00;
         o_expired <= 1'b0;
      end else begin
         pre_r <= tick ? {PRE_W{1'b0}} : pre_r + 1'b1;
         if (tick && tenth_r != 6'h3f)
            tenth_r <= tenth_r + 6'h01;
         if (tenth_r >= i_period)
            o_expired <= 1'b1;
      end
   end

endmodule // fbw_loss_timer
`default_nettype wire
